// >>> verilog/bsb_serial_bridge.sv
/*
  biphase-mark bridge between the connected CC pin and a controller's slave serial port.
  holds the link-clock codec and the CC pin selection; the serial port side runs on CLK.
  assumes LINK_CLK runs free, CC inputs and strap levels are asynchronous pins.
*/
`timescale 1ns/1ps

`include "bsb_defines.svh"

// Functional notes
// R1: receive data is put on MOSI before the serial clock falls, sampled there.
// R2: in transmit, MISO is sampled at the serial clock rising edge, then encoded.
// R3: the bridge drives frame select itself to open every serial transfer.
// R4: the bridge alone generates the serial clock for both data directions.
// R5: while transmit request is high, controller bits are encoded onto the CC line.
// R6: without transmit request the bridge listens, decodes, and forwards bits on MOSI.
// R7: transmit request overrides any reception in progress.
// R8: request drop ends the frame with a trailing edge and releases the CC line.
// R9: frame select returns high once line activity stops.
// R10: during reception frame select is low and the clock follows recovered bits.
// R11: codec touches only the CC pin of the attachment, and none when unattached.
// R12: every bit boundary toggles the line; a one adds a mid-bit toggle.
module bsb_serial_bridge (
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic CE,
  input  wire logic LINK_CLK,
  input  wire logic TX_EN,
  input  wire logic MISO,
  output logic      MOSI,
  output logic      SCLK,
  output logic      FRAME_SELECT_N,
  input  wire logic ATTACHED,
  input  wire logic CC2_SEL,
  input  wire logic CC1_I,
  output logic      CC1_O,
  output logic      CC1_OE,
  input  wire logic CC2_I,
  output logic      CC2_O,
  output logic      CC2_OE
);
  import bsb_pkg::*;

  bsb_link_if lk ();

  // ****************************************
  // serial port side
  // ****************************************
  bsb_port_engine u_eng (
    .clk         (CLK),
    .srst        (SRST),
    .ce          (CE),
    .tx_en       (TX_EN),
    .miso        (MISO),
    .sclk        (SCLK),
    .mosi        (MOSI),
    .frame_sel_n (FRAME_SELECT_N),
    .lk          (lk.eng)
  );

  // ****************************************
  // link-domain synchronisers
  // ****************************************
  logic [`BSB_SY_W-1:0]   sy1_reg, sy2_reg;
  logic                   ack_d_reg;
  logic [`BSB_SY_W-1:0]   sy_in;

  assign sy_in = {CC2_I, CC1_I, CC2_SEL, ATTACHED, lk.ack_tgl, lk.tx_mode, CE, SRST};

  always_ff @(posedge LINK_CLK) begin
    sy1_reg <= sy_in;
    sy2_reg <= sy1_reg;
  end

  logic rst_l, ce_l, att_l, ori_l, ack_edge, tx_req_l, cc_in;

  assign rst_l    = sy2_reg[`BSB_SY_RST];
  assign ce_l     = sy2_reg[`BSB_SY_CE];
  assign att_l    = sy2_reg[`BSB_SY_ATT];
  assign ori_l    = sy2_reg[`BSB_SY_ORI];
  assign ack_edge = sy2_reg[`BSB_SY_ACK] ^ ack_d_reg;
  assign tx_req_l = sy2_reg[`BSB_SY_TXM] & att_l;
  assign cc_in    = ori_l ? sy2_reg[`BSB_SY_CC2] : sy2_reg[`BSB_SY_CC1]; // [R11]

  // ****************************************
  // encoder
  // ****************************************
  bsb_tx_st_t             tx_st_reg, tx_st_next;
  logic [`BSB_CNT_W-1:0]  tcnt_reg, tcnt_next;
  logic                   lvl_reg, lvl_next;
  logic                   oe1_reg, oe1_next;
  logic                   oe2_reg, oe2_next;
  logic                   cur_reg, cur_next;
  logic                   nbit_reg, nbit_next;
  logic                   have_reg, have_next;
  logic                   req_reg, req_next;
  logic                   drive;

  always_comb begin
    tx_st_next = tx_st_reg;
    tcnt_next  = tcnt_reg;
    lvl_next   = lvl_reg;
    cur_next   = cur_reg;
    nbit_next  = nbit_reg;
    have_next  = have_reg;
    req_next   = req_reg;
    drive      = 1'b0;
    if (ack_edge) begin
      nbit_next = lk.tx_bit;
      have_next = 1'b1;
    end
    case (tx_st_reg)
      TX_IDLE: begin
        lvl_next = 1'b0;
        if (tx_req_l) begin                                   // [R5] [R7]
          tx_st_next = TX_FETCH;
          req_next   = ~req_reg;
          have_next  = 1'b0;
        end
      end
      TX_FETCH: begin
        if (ack_edge) begin
          tx_st_next = TX_BIT;
          drive      = 1'b1;
          cur_next   = lk.tx_bit;
          lvl_next   = ~lvl_reg;                              // [R12]
          tcnt_next  = `BSB_CNT_W'(`BSB_UI_CYC - 1);
          req_next   = ~req_reg;
          have_next  = 1'b0;
        end else if (!tx_req_l) begin
          tx_st_next = TX_IDLE;
        end
      end
      TX_BIT: begin
        drive     = 1'b1;
        tcnt_next = tcnt_reg - 1'b1;
        if (tcnt_reg == `BSB_CNT_W'(`BSB_HALF_CYC) && cur_reg) begin
          lvl_next = ~lvl_reg;                                // [R12]
        end
        if (tcnt_reg == '0) begin
          lvl_next = ~lvl_reg;                                // [R12]
          if (tx_req_l && have_reg) begin
            cur_next  = nbit_reg;
            tcnt_next = `BSB_CNT_W'(`BSB_UI_CYC - 1);
            req_next  = ~req_reg;
            have_next = 1'b0;
          end else begin
            tx_st_next = TX_TAIL;                             // [R8]
            tcnt_next  = `BSB_CNT_W'(`BSB_HALF_CYC - 1);
          end
        end
      end
      TX_TAIL: begin
        drive     = 1'b1;
        tcnt_next = tcnt_reg - 1'b1;
        if (tcnt_reg == '0) begin
          tx_st_next = TX_IDLE;                               // [R8]
          lvl_next   = 1'b0;
          drive      = 1'b0;
        end
      end
      default: begin
        tx_st_next = TX_IDLE;
      end
    endcase
    oe1_next = drive & att_l & ~ori_l;                        // [R11]
    oe2_next = drive & att_l & ori_l;                         // [R11]
  end

  always_ff @(posedge LINK_CLK) begin
    if (rst_l) begin
      tx_st_reg <= TX_IDLE;
      tcnt_reg  <= '0;
      lvl_reg   <= 1'b0;
      oe1_reg   <= 1'b0;
      oe2_reg   <= 1'b0;
      cur_reg   <= 1'b0;
      nbit_reg  <= 1'b0;
      have_reg  <= 1'b0;
      req_reg   <= 1'b0;
      ack_d_reg <= 1'b0;
    end else if (ce_l) begin
      tx_st_reg <= tx_st_next;
      tcnt_reg  <= tcnt_next;
      lvl_reg   <= lvl_next;
      oe1_reg   <= oe1_next;
      oe2_reg   <= oe2_next;
      cur_reg   <= cur_next;
      nbit_reg  <= nbit_next;
      have_reg  <= have_next;
      req_reg   <= req_next;
      ack_d_reg <= sy2_reg[`BSB_SY_ACK];
    end
  end

  // ****************************************
  // decoder and activity detect
  // ****************************************
  logic [`BSB_CNT_W-1:0]  rcnt_reg, rcnt_next;
  logic                   half_reg, half_next;
  logic                   act_reg, act_next;
  logic                   rtgl_reg, rtgl_next;
  logic                   rbit_reg, rbit_next;
  logic                   last_reg, last_next;
  logic [2:0]             echo_reg, echo_next;
  logic                   edge_seen;

  always_comb begin
    rcnt_next = rcnt_reg;
    half_next = half_reg;
    act_next  = act_reg;
    rtgl_next = rtgl_reg;
    rbit_next = rbit_reg;
    last_next = cc_in;
    echo_next = {echo_reg[1:0], tx_st_reg != TX_IDLE};
    edge_seen = att_l && (cc_in != last_reg);                 // [R11]
    if (tx_req_l || tx_st_reg != TX_IDLE || echo_reg != 3'h0) begin // [R8]
      act_next  = 1'b0;                                       // [R7]
      rcnt_next = '0;
      half_next = 1'b0;
    end else if (edge_seen) begin
      rcnt_next = '0;
      if (!act_reg) begin
        act_next  = 1'b1;                                     // [R6]
        half_next = 1'b0;
      end else if (rcnt_reg < `BSB_CNT_W'(`BSB_THREEQ_CYC)) begin
        half_next = 1'b1;
        rcnt_next = rcnt_reg + 1'b1;
      end else begin
        rbit_next = half_reg;                                 // [R6] [R12]
        rtgl_next = ~rtgl_reg;
        half_next = 1'b0;
      end
    end else if (act_reg) begin
      if (rcnt_reg == `BSB_CNT_W'(`BSB_IDLE_CYC)) begin
        act_next = 1'b0;                                      // [R9]
      end else begin
        rcnt_next = rcnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (rst_l) begin
      rcnt_reg <= '0;
      half_reg <= 1'b0;
      act_reg  <= 1'b0;
      rtgl_reg <= 1'b0;
      rbit_reg <= 1'b0;
      last_reg <= 1'b0;
      echo_reg <= 3'h0;
    end else if (ce_l) begin
      rcnt_reg <= rcnt_next;
      half_reg <= half_next;
      act_reg  <= act_next;
      rtgl_reg <= rtgl_next;
      rbit_reg <= rbit_next;
      last_reg <= last_next;
      echo_reg <= echo_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign lk.req_tgl   = req_reg;
  assign lk.rx_tgl    = rtgl_reg;
  assign lk.rx_bit    = rbit_reg;
  assign lk.rx_active = act_reg;
  assign CC1_O        = lvl_reg;
  assign CC2_O        = lvl_reg;
  assign CC1_OE       = oe1_reg;
  assign CC2_OE       = oe2_reg;

endmodule // bsb_serial_bridge

// >>> verilog/bsb_defines.svh
/*
  timing counts and synchroniser bit positions for the biphase-mark serial bridge.
  assumes CLK at 25 MHz and a free-running link clock of 80 ns period.
*/
`ifndef BSB_DEFINES_SVH
`define BSB_DEFINES_SVH

// ****************************************
// clock periods
// ****************************************
`define BSB_CLK_PERIOD_NS   40
`define BSB_LINK_PERIOD_NS  80

// ****************************************
// link-side bit timing
// ****************************************
`define BSB_UI_NS           3200
`define BSB_UI_CYC          (`BSB_UI_NS / `BSB_LINK_PERIOD_NS)
`define BSB_HALF_CYC        (`BSB_UI_CYC / 2)
`define BSB_THREEQ_CYC      ((`BSB_UI_CYC * 3) / 4)
`define BSB_IDLE_CYC        (`BSB_UI_CYC * 2)
`define BSB_CNT_W           7

// ****************************************
// serial port timing
// ****************************************
`define BSB_SCLK_HALF_NS    400
`define BSB_SCLK_HALF_CYC   ((`BSB_SCLK_HALF_NS + `BSB_CLK_PERIOD_NS - 1) / `BSB_CLK_PERIOD_NS)
`define BSB_SCLK_W          4

// ****************************************
// link-domain synchroniser bit positions
// ****************************************
`define BSB_SY_W            8
`define BSB_SY_RST          0
`define BSB_SY_CE           1
`define BSB_SY_TXM          2
`define BSB_SY_ACK          3
`define BSB_SY_ATT          4
`define BSB_SY_ORI          5
`define BSB_SY_CC1          6
`define BSB_SY_CC2          7

`endif

// >>> verilog/bsb_pkg.sv
/*
  types shared by the bridge modules.
  assumes nothing beyond a SystemVerilog compiler.
*/
package bsb_pkg;

  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_BIT, TX_TAIL} bsb_tx_st_t;
  typedef enum logic [1:0] {SP_IDLE, SP_LOW, SP_HIGH} bsb_sp_st_t;

endpackage : bsb_pkg

// >>> verilog/bsb_link_if.sv
/*
  crossing signals between the serial port engine (CLK) and the codec (link clock).
  assumes each side synchronises what it receives except tx_bit and rx_bit; all signals come from flip-flops.
*/
`timescale 1ns/1ps

interface bsb_link_if;
  logic tx_mode;     // clk: transmit mode level
  logic ack_tgl;     // clk: toggles when tx_bit holds a fresh bit
  logic tx_bit;      // clk: bit taken from the controller
  logic req_tgl;     // link: toggles to ask for the next bit
  logic rx_tgl;      // link: toggles when rx_bit holds a decoded bit
  logic rx_bit;      // link: decoded bit
  logic rx_active;   // link: line activity seen

  modport eng (output tx_mode, ack_tgl, tx_bit, input req_tgl, rx_tgl, rx_bit, rx_active);
  modport cdc (input tx_mode, ack_tgl, tx_bit, output req_tgl, rx_tgl, rx_bit, rx_active);
endinterface : bsb_link_if

// >>> verilog/bsb_port_engine.sv
/*
  serial port engine on CLK: makes the serial clock and frame select, takes bits
  from the controller and presents decoded bits to it.
  assumes tx_en and miso come straight from pins; link signals arrive unsynchronised.
*/
`timescale 1ns/1ps

`include "bsb_defines.svh"

module bsb_port_engine (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic tx_en,
  input  wire logic miso,
  output logic      sclk,
  output logic      mosi,
  output logic      frame_sel_n,
  bsb_link_if.eng   lk
);
  import bsb_pkg::*;

  // ****************************************
  // synchronisers
  // ****************************************
  logic                    tx_en_s1_reg, tx_en_s2_reg;
  logic                    miso_s1_reg, miso_s2_reg;
  logic                    req_s1_reg, req_s2_reg, req_s3_reg;
  logic                    rxt_s1_reg, rxt_s2_reg, rxt_s3_reg;
  logic                    act_s1_reg, act_s2_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      {tx_en_s1_reg, tx_en_s2_reg, miso_s1_reg, miso_s2_reg} <= 4'h0;
      {req_s1_reg, req_s2_reg, req_s3_reg} <= 3'h0;
      {rxt_s1_reg, rxt_s2_reg, rxt_s3_reg} <= 3'h0;
      {act_s1_reg, act_s2_reg} <= 2'h0;
    end else if (ce) begin
      tx_en_s1_reg <= tx_en;
      tx_en_s2_reg <= tx_en_s1_reg;
      miso_s1_reg  <= miso;
      miso_s2_reg  <= miso_s1_reg;
      req_s1_reg   <= lk.req_tgl;
      req_s2_reg   <= req_s1_reg;
      req_s3_reg   <= req_s2_reg;
      rxt_s1_reg   <= lk.rx_tgl;
      rxt_s2_reg   <= rxt_s1_reg;
      rxt_s3_reg   <= rxt_s2_reg;
      act_s1_reg   <= lk.rx_active;
      act_s2_reg   <= act_s1_reg;
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  bsb_sp_st_t              st_reg, st_next;
  logic [`BSB_SCLK_W-1:0]  cnt_reg, cnt_next;
  logic                    xtx_reg, xtx_next;
  logic                    sclk_reg, sclk_next;
  logic                    mosi_reg, mosi_next;
  logic                    frame_n_reg, frame_n_next;
  logic                    ack_reg, ack_next;
  logic                    bit_reg, bit_next;
  logic                    req_edge, rx_edge;

  always_comb begin
    st_next      = st_reg;
    cnt_next     = cnt_reg;
    xtx_next     = xtx_reg;
    sclk_next    = sclk_reg;
    mosi_next    = mosi_reg;
    ack_next     = ack_reg;
    bit_next     = bit_reg;
    req_edge     = req_s2_reg ^ req_s3_reg;
    rx_edge      = rxt_s2_reg ^ rxt_s3_reg;
    case (st_reg)
      SP_IDLE: begin
        if (tx_en_s2_reg && req_edge) begin
          st_next  = SP_LOW;
          xtx_next = 1'b1;
          cnt_next = `BSB_SCLK_W'(`BSB_SCLK_HALF_CYC - 1);
        end else if (!tx_en_s2_reg && rx_edge) begin
          st_next   = SP_LOW;
          xtx_next  = 1'b0;
          mosi_next = lk.rx_bit;                              // [R1] [R6]
          cnt_next  = `BSB_SCLK_W'(`BSB_SCLK_HALF_CYC - 1);
        end
      end
      SP_LOW: begin
        sclk_next = 1'b0;
        if (cnt_reg == '0) begin
          st_next   = SP_HIGH;
          sclk_next = 1'b1;                                   // [R4] [R10]
          cnt_next  = `BSB_SCLK_W'(`BSB_SCLK_HALF_CYC - 1);
          if (xtx_reg) begin
            bit_next = miso_s2_reg;                           // [R2]
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      SP_HIGH: begin
        if (cnt_reg == '0) begin
          st_next   = SP_IDLE;
          sclk_next = 1'b0;                                   // [R1]
          if (xtx_reg) begin
            ack_next = ~ack_reg;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        st_next   = SP_IDLE;
        sclk_next = 1'b0;
      end
    endcase
    frame_n_next = !(tx_en_s2_reg || act_s2_reg || st_reg != SP_IDLE); // [R3] [R9] [R10]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg      <= SP_IDLE;
      cnt_reg     <= '0;
      xtx_reg     <= 1'b0;
      sclk_reg    <= 1'b0;
      mosi_reg    <= 1'b0;
      frame_n_reg <= 1'b1;
      ack_reg     <= 1'b0;
      bit_reg     <= 1'b0;
    end else if (ce) begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      xtx_reg     <= xtx_next;
      sclk_reg    <= sclk_next;
      mosi_reg    <= mosi_next;
      frame_n_reg <= frame_n_next;
      ack_reg     <= ack_next;
      bit_reg     <= bit_next;
    end
  end

  assign sclk        = sclk_reg;
  assign mosi        = mosi_reg;
  assign frame_sel_n = frame_n_reg;
  assign lk.tx_mode  = tx_en_s2_reg;  // [R5] [R7]
  assign lk.ack_tgl  = ack_reg;
  assign lk.tx_bit   = bit_reg;

endmodule // bsb_port_engine

// >>> verification/bsb_serial_bridge_sva.sv
/* checker on the bridge top-level ports.
   assumes binding to bsb_serial_bridge and CC2_SEL held while a pin is driven. */
`timescale 1ns/1ps

module bsb_serial_bridge_sva (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic TX_EN,
  input wire logic SCLK,
  input wire logic MOSI,
  input wire logic FRAME_SELECT_N,
  input wire logic CC2_SEL,
  input wire logic CC1_OE,
  input wire logic CC2_OE
);
  // ****************************************
  // serial clock, frame select, pin drive
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_high10; SCLK [*8] ##1 SCLK [*2] ##1 !SCLK; endsequence
  sequence s_low10; !SCLK [*8] ##1 !SCLK [*2]; endsequence
  property p_sclk_high; $rose(SCLK) |-> s_high10; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("serial clock high time wrong");
  property p_sclk_low; $fell(SCLK) |-> s_low10; endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("serial clock low time wrong");
  property p_sclk_framed; SCLK |-> !FRAME_SELECT_N; endproperty
  a_sclk_framed: assert property (p_sclk_framed) else $error("clock outside frame");
  property p_mosi_hold; SCLK |-> $stable(MOSI); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
  property p_tx_select; $rose(TX_EN) |-> ##[1:5] !FRAME_SELECT_N; endproperty
  a_tx_select: assert property (p_tx_select) else $error("frame select late");
  property p_oe_excl; !(CC1_OE && CC2_OE); endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both pins driven");
  property p_oe_pin; (CC1_OE || CC2_OE) |-> (CC2_OE == CC2_SEL); endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("wrong pin driven");
  property p_oe_release; $fell(TX_EN) |-> ##[1:400] !(CC1_OE || CC2_OE); endproperty
  a_oe_release: assert property (p_oe_release) else $error("line not released");
endmodule // bsb_serial_bridge_sva

bind bsb_serial_bridge bsb_serial_bridge_sva u_sva (.CLK(CLK), .SRST(SRST), .TX_EN(TX_EN), .SCLK(SCLK),
  .MOSI(MOSI), .FRAME_SELECT_N(FRAME_SELECT_N), .CC2_SEL(CC2_SEL), .CC1_OE(CC1_OE), .CC2_OE(CC2_OE));

// >>> verification/bsb_mcu_model.sv
/* controller model on the slave serial port.
   assumes the bridge makes the serial clock and frame select. */
`timescale 1ns/1ps

module bsb_mcu_model (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic sclk,
  input  wire logic frame_sel_n,
  input  wire logic mosi,
  output logic      tx_en,
  output logic      miso
);
  // ****************************************
  // transmit feed and receive capture
  // ****************************************
  logic [15:0] tx_bits;
  int          taken;
  logic        rxq[$];
  initial begin
    tx_en = 1'b0;
    miso  = 1'b0;
    taken = 0;
  end
  // released data line keeps changing
  always @(negedge clk) if (!tx_en) miso <= ~miso;
  // next bit after each fall, stable over the rise
  always @(negedge sclk) if (tx_en) begin
    taken = taken + 1;
    #(slow ? 310 : 5) miso = tx_bits[taken];
  end
  // decoded bits taken at the falling edge
  always @(negedge sclk) if (!tx_en && !frame_sel_n) rxq.push_back(mosi);
  // request, bits, release after the discarded fetch
  task automatic send(input logic [15:0] bits, input int n, input int lim);
    int k;
    k = 0;
    tx_bits = bits;
    taken = 0;
    @(posedge clk);
    miso  <= bits[0];
    tx_en <= 1'b1;
    while (taken < n + 1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    tx_en <= 1'b0;
  endtask
endmodule // bsb_mcu_model

// >>> verification/bsb_serial_bridge_bench.sv
/* bench for the biphase-mark serial bridge.
   assumes the controller model on the serial port and a far end driven here on CC. */
`timescale 1ns/1ps

`define BSB_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp); end end

module bsb_serial_bridge_bench;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic CLK = 1'b0, LINK_CLK = 1'b0, SRST = 1'b1, ATTACHED = 1'b0, CC2_SEL = 1'b0;
  logic slow = 1'b0, cc1_drv = 1'b0, cc2_drv = 1'b0, oe_seen = 1'b0;
  logic MOSI, SCLK, FRAME_SELECT_N, TX_EN, MISO, CC1_O, CC1_OE, CC2_O, CC2_OE;
  wire  cc1_w = CC1_OE ? CC1_O : cc1_drv;
  wire  cc2_w = CC2_OE ? CC2_O : cc2_drv;
  int   fails = 0, n_compared = 0, cyc = 0;
  bsb_serial_bridge uut (.CLK(CLK), .SRST(SRST), .CE(1'b1), .LINK_CLK(LINK_CLK), .TX_EN(TX_EN),
    .MISO(MISO), .MOSI(MOSI), .SCLK(SCLK), .FRAME_SELECT_N(FRAME_SELECT_N), .ATTACHED(ATTACHED),
    .CC2_SEL(CC2_SEL), .CC1_I(cc1_w), .CC1_O(CC1_O), .CC1_OE(CC1_OE), .CC2_I(cc2_w),
    .CC2_O(CC2_O), .CC2_OE(CC2_OE));
  bsb_mcu_model mcu (.clk(CLK), .slow(slow), .sclk(SCLK), .frame_sel_n(FRAME_SELECT_N),
    .mosi(MOSI), .tx_en(TX_EN), .miso(MISO));
  always #20 CLK = ~CLK;
  initial begin
    #7;
    forever #40 LINK_CLK = ~LINK_CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (CC1_OE || CC2_OE) oe_seen <= 1'b1;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic wl(input logic sel);
    return sel ? cc2_w : cc1_w;
  endfunction
  task automatic flip(input int pin);
    @(posedge LINK_CLK);
    if (pin == 2) cc2_drv <= ~cc2_drv;
    else cc1_drv <= ~cc1_drv;
  endtask
  // leading edge, then per bit a mid toggle for one and a boundary toggle
  task automatic bmc_out(input int pin, input logic [15:0] bits, input int n);
    int i;
    flip(pin);
    for (i = 0; i < n; i++) begin
      repeat (19) @(posedge LINK_CLK);
      if (bits[i]) flip(pin);
      else @(posedge LINK_CLK);
      repeat (19) @(posedge LINK_CLK);
      flip(pin);
    end
    // half-bit hold, then release to idle low
    repeat (20) @(posedge LINK_CLK);
    if (pin == 2) cc2_drv <= 1'b0;
    else cc1_drv <= 1'b0;
  endtask
  task automatic t_rx(input logic sel, input int pin);
    int i;
    logic [15:0] bits;
    bits = 16'h004d;
    @(posedge CLK);
    CC2_SEL <= sel;
    oe_seen <= 1'b0;
    mcu.rxq.delete();
    repeat (5) @(posedge LINK_CLK);
    bmc_out(pin, bits, 8);
    `BSB_CHK(FRAME_SELECT_N, (pin - 1 == sel) ? 1'b0 : 1'b1)
    repeat (130) @(posedge LINK_CLK);
    `BSB_CHK(FRAME_SELECT_N, 1'b1)
    `BSB_CHK(oe_seen, 1'b0)
    `BSB_CHK(mcu.rxq.size(), (pin - 1 == sel) ? 8 : 0)
    for (i = 0; i < 8 && pin - 1 == sel; i++) begin
      `BSB_CHK(mcu.rxq[i], bits[i])
    end
  endtask
  task automatic tx_check(input logic sel, input logic [15:0] bits, input int n);
    int   i;
    int   k;
    logic a;
    logic b;
    k = 0;
    b = 1'b0;
    fork
      mcu.send(bits, n, 3000);
    join_none
    while (!(wl(sel) && (sel ? CC2_OE : CC1_OE)) && k < 3000) begin
      @(posedge LINK_CLK);
      k++;
    end
    `BSB_CHK(k < 3000, 1'b1)
    `BSB_CHK(FRAME_SELECT_N, 1'b0)
    for (i = 0; i <= n; i++) begin
      repeat (10) @(posedge LINK_CLK);
      a = wl(sel);
      if (i > 0) `BSB_CHK(a, ~b)
      repeat (20) @(posedge LINK_CLK);
      b = wl(sel);
      if (i < n) `BSB_CHK(a ^ b, bits[i])
      repeat (10) @(posedge LINK_CLK);
    end
    `BSB_CHK(CC1_OE | CC2_OE, 1'b0)
  endtask
  task automatic t_tx();
    @(posedge CLK);
    CC2_SEL <= 1'b0;
    tx_check(1'b0, 16'h002d, 6);
    @(posedge CLK);
    CC2_SEL <= 1'b1;
    slow <= 1'b1;
    tx_check(1'b1, 16'h0135, 9);
  endtask
  task automatic t_prio();
    @(posedge CLK);
    CC2_SEL <= 1'b0;
    slow <= 1'b0;
    repeat (5) @(posedge LINK_CLK);
    bmc_out(1, 16'h0005, 3);
    tx_check(1'b0, 16'h0033, 7);
  endtask
  task automatic t_unattached();
    @(posedge CLK);
    ATTACHED <= 1'b0;
    oe_seen <= 1'b0;
    mcu.send(16'h0003, 2, 400);
    `BSB_CHK(oe_seen, 1'b0)
    SRST <= 1'b1;
    repeat (10) @(posedge CLK);
    `BSB_CHK({SCLK, FRAME_SELECT_N, CC1_OE, CC2_OE}, 4'b0100)
    SRST <= 1'b0;
    repeat (2) @(posedge CLK);
    `BSB_CHK({SCLK, FRAME_SELECT_N}, 2'b01)
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    ATTACHED <= 1'b1;
    repeat (20) @(posedge CLK);
    t_rx(1'b0, 1);
    t_rx(1'b0, 2);
    t_rx(1'b1, 2);
    t_tx();
    t_prio();
    t_unattached();
    wrap_up();
  end
endmodule // bsb_serial_bridge_bench
